// ---- core/accel_frame_core.sv ----
// Operation
// - Response payload follows last accepted type, echoed in status bits 2:0.
// - Acceleration data bytes: Y high, Y low, X high, X low.
// - Status response: byte two zero, temperature high then low.
// - Status byte one: axis faults, vref, sense cap, self-test, one.
// - Axis pair bit0 is Y, bit1 is X; one means fail.
// - Byte one bit 2 flags OTP parity failure.
// - Byte one bit 1 flags bad checksum on previous input.
// - Sixth byte is inverted low byte of sum of first five.
// - Bad-checksum frames are discarded and flagged in next status.
// - After a rejected frame keep the last good message type.
// - Power-up selects the acceleration response type.
// - Freeze data, compute checksum, then load the shift register.
// - Self-test adds a fixed offset to both acceleration outputs.
// - Offset fully applied within 35 ms of request.
// - Six bytes each way, MSB first.
// - Slave only, clock polarity zero, phase zero.
// - Measurement words are two's complement, high byte first.
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module accel_frame_core #(
    parameter int SETTLE_CYC = accel_frame_pkg::SELFTEST_CYC
) (
    input  wire logic        clk_sys_i,
    input  wire logic        srst_i,
    // Serial link pins
    input  wire logic        sclk_i,
    input  wire logic        sel_n_i,
    input  wire logic        mosi_i,
    output logic             miso_o,
    output logic             miso_oe_o,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic [1:0] sclk_s_r;
    logic [1:0] sel_s_r;
    logic [1:0] mosi_s_r;
    logic       sclk_d_r;

    // Second stage only feeds logic; first stage feeds nothing else
    always_ff @(posedge clk_sys_i) begin
        sclk_s_r <= {sclk_s_r[0], sclk_i};
        sel_s_r  <= {sel_s_r[0], sel_n_i};
        mosi_s_r <= {mosi_s_r[0], mosi_i};
        sclk_d_r <= sclk_s_r[1];
    end

    wire sclk_q   = sclk_s_r[1];
    wire selected = ~sel_s_r[1];
    wire rise     = selected & sclk_q & ~sclk_d_r;
    wire fall     = selected & ~sclk_q & sclk_d_r;

    // ==========================================================
    // Register file
    // ==========================================================
    logic [15:0]                 accel_y_r;
    logic [15:0]                 accel_x_r;
    logic [15:0]                 temp_r;
    logic [15:0]                 offset_r;
    accel_frame_pkg::fault_t     fault_r;
    logic                        selftest_r;
    logic                        settled_r;
    logic                        csum_err_r;
    logic [2:0]                  msg_type_r;
    logic [$clog2(SETTLE_CYC+2)-1:0] settle_cnt_r;

    // Write channel: take address and data in either order
    logic        aw_hold_r;
    logic        w_hold_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_hold_r & ~s_axi_bvalid;
    wire aw_now   = aw_hold_r | (s_axi_awvalid & s_axi_awready);
    wire w_now    = w_hold_r | (s_axi_wvalid & s_axi_wready);
    wire [7:0]  wa = aw_hold_r ? awaddr_r : s_axi_awaddr;
    wire [31:0] wd = w_hold_r ? wdata_r : s_axi_wdata;
    wire do_wr    = aw_now & w_now & ~s_axi_bvalid;
    wire wr_ctrl  = do_wr && wa == accel_frame_pkg::REG_CTRL;
    wire wr_accel = do_wr && wa == accel_frame_pkg::REG_ACCEL;
    wire wr_temp  = do_wr && wa == accel_frame_pkg::REG_TEMP;
    wire wr_fault = do_wr && wa == accel_frame_pkg::REG_FAULT;
    wire wr_off   = do_wr && wa == accel_frame_pkg::REG_OFFSET;
    wire wr_hit   = wr_ctrl | wr_accel | wr_temp | wr_fault | wr_off;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            aw_hold_r    <= 1'b0;
            w_hold_r     <= 1'b0;
            awaddr_r     <= 8'h00;
            wdata_r      <= 32'h0000_0000;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= accel_frame_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid & s_axi_awready & ~do_wr) begin
                aw_hold_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready & ~do_wr) begin
                w_hold_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
            end
            if (do_wr) begin
                aw_hold_r    <= 1'b0;
                w_hold_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? accel_frame_pkg::RESP_OKAY
                                       : accel_frame_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Sensor values and faults; byte strobes ignored, full words only
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            accel_y_r <= 16'h0000;
            accel_x_r <= 16'h0000;
            temp_r    <= 16'h0000;
            fault_r   <= '0;
            offset_r  <= accel_frame_pkg::OFFSET_RST;
        end else begin
            if (wr_accel) begin
                accel_y_r <= wd[31:16];
                accel_x_r <= wd[15:0];
            end
            if (wr_temp) temp_r <= wd[15:0];
            if (wr_fault) fault_r <= wd[5:0];
            if (wr_off) offset_r <= wd[15:0];
        end
    end

    // Read channel
    wire [31:0] rd_mux =
        (s_axi_araddr == accel_frame_pkg::REG_ACCEL)  ? {accel_y_r, accel_x_r} :
        (s_axi_araddr == accel_frame_pkg::REG_TEMP)   ? {16'h0000, temp_r} :
        (s_axi_araddr == accel_frame_pkg::REG_FAULT)  ? {26'h0, fault_r} :
        (s_axi_araddr == accel_frame_pkg::REG_OFFSET) ? {16'h0000, offset_r} :
        (s_axi_araddr == accel_frame_pkg::REG_STATUS) ?
            {26'h0, settled_r, selftest_r, csum_err_r, msg_type_r} :
        32'h0000_0000;
    wire rd_hit = s_axi_araddr == accel_frame_pkg::REG_ACCEL
               || s_axi_araddr == accel_frame_pkg::REG_TEMP
               || s_axi_araddr == accel_frame_pkg::REG_FAULT
               || s_axi_araddr == accel_frame_pkg::REG_OFFSET
               || s_axi_araddr == accel_frame_pkg::REG_STATUS
               || s_axi_araddr == accel_frame_pkg::REG_CTRL;
    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= accel_frame_pkg::RESP_OKAY;
        end else if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_hit ? accel_frame_pkg::RESP_OKAY
                                   : accel_frame_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Serial receive and command check
    // ==========================================================
    logic [47:0] rx_r;
    logic [5:0]  bit_cnt_r;
    logic [47:0] tx_r;

    wire [47:0] rx_full = {rx_r[46:0], mosi_s_r[1]};
    wire [9:0]  rx_sum = 10'(rx_full[47:40]) + 10'(rx_full[39:32]) + 10'(rx_full[31:24])
                       + 10'(rx_full[23:16]) + 10'(rx_full[15:8]);
    wire [7:0]  rx_csum = ~rx_sum[7:0];
    wire frame_done = rise && bit_cnt_r == 6'(accel_frame_pkg::FRAME_BITS - 1);
    wire csum_ok    = rx_csum == rx_full[7:0];
    wire [3:0] cmd_type = rx_full[43:40];
    wire type_known = cmd_type == accel_frame_pkg::MSG_ACCEL
                   || cmd_type == accel_frame_pkg::MSG_STATUS;

    // Shift in on rising edges, count bits within the select window
    always_ff @(posedge clk_sys_i) begin
        if (srst_i || !selected) begin
            bit_cnt_r <= 6'h00;
            rx_r      <= 48'h0;
        end else if (rise) begin
            rx_r      <= rx_full;
            bit_cnt_r <= frame_done ? 6'h00 : bit_cnt_r + 6'h01;
        end
    end

    // Command decode: good frames update self-test and, for known types, type; bad ones only flag
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            msg_type_r <= accel_frame_pkg::MSG_RESET;
            selftest_r <= 1'b0;
            csum_err_r <= 1'b0;
        end else if (frame_done) begin
            csum_err_r <= ~csum_ok;
            if (csum_ok) begin
                selftest_r <= rx_full[40 + accel_frame_pkg::CMD_SELFTEST_BIT];
                if (type_known) msg_type_r <= cmd_type[2:0];
            end
        end else if (wr_ctrl) begin
            selftest_r <= wd[0];
        end
    end

    // ==========================================================
    // Self-test settle timer
    // ==========================================================
    // offset applied at once, settle flag within the limit
    always_ff @(posedge clk_sys_i) begin
        if (srst_i || !selftest_r) begin
            settle_cnt_r <= '0;
            settled_r    <= 1'b0;
        end else if (settle_cnt_r < ($bits(settle_cnt_r))'(SETTLE_CYC)) begin
            settle_cnt_r <= settle_cnt_r + 1'b1;
        end else begin
            settled_r <= 1'b1;
        end
    end

    // offset on both axes, two's complement
    wire [15:0] acc_y_out = selftest_r ? 16'(accel_y_r + offset_r) : accel_y_r;
    wire [15:0] acc_x_out = selftest_r ? 16'(accel_x_r + offset_r) : accel_x_r;

    // ==========================================================
    // Response assembly
    // ==========================================================
    // status payload byte one
    wire [7:0] stat_b1 = {fault_r.axis, fault_r.vref_cap, fault_r.acc_cap,
                          selftest_r, fault_r.otp_parity, csum_err_r, 1'b1};
    wire is_status = msg_type_r == accel_frame_pkg::MSG_STATUS[2:0];
    wire [31:0] data_sel = is_status ? {stat_b1, 8'h00, temp_r}
                                     : {acc_y_out, acc_x_out};
    wire [7:0] head = {fault_r.sensor, fault_r.axis[0], fault_r.axis[1],
                       csum_err_r, selftest_r, msg_type_r};

    logic [31:0] data_frz_r;
    logic [7:0]  csum_r;
    logic [31:0] data_stg_r;
    logic        sel_d_r;
    wire frame_start = selected & ~sel_d_r;
    wire [9:0] tx_sum = 10'(head) + 10'(data_stg_r[31:24]) + 10'(data_stg_r[23:16])
                      + 10'(data_stg_r[15:8]) + 10'(data_stg_r[7:0]);

    // freeze data, checksum it, then keep both as one pair so a load is consistent while head is stable
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            data_stg_r <= 32'h0;
            data_frz_r <= 32'h0;
            csum_r     <= 8'h00;
            sel_d_r    <= 1'b0;
        end else begin
            sel_d_r <= selected;
            if (!selected) begin
                data_stg_r <= data_sel;
                data_frz_r <= data_stg_r;
                csum_r     <= ~tx_sum[7:0];
            end
        end
    end

    // Transmit: load on select, shift on falling edge, MSB first
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            tx_r <= 48'h0;
        end else if (frame_start) begin
            tx_r <= {head, data_frz_r, csum_r};
        end else if (fall) begin
            tx_r <= {tx_r[46:0], 1'b0};
        end
    end

    assign miso_o    = tx_r[47];
    assign miso_oe_o = selected;

    // ==========================================================
    // Checks
    // ==========================================================
    property p_frame_flag;
        @(posedge clk_sys_i) disable iff (srst_i)
        frame_done |=> csum_err_r == $past(~csum_ok);
    endproperty
    a_frame_flag: assert property (p_frame_flag) else $error("checksum flag wrong");

    property p_keep_type;
        @(posedge clk_sys_i) disable iff (srst_i)
        (frame_done && !csum_ok) |=> $stable(msg_type_r);
    endproperty
    a_keep_type: assert property (p_keep_type) else $error("type changed on bad frame");

    property p_take_type;
        @(posedge clk_sys_i) disable iff (srst_i)
        (frame_done && csum_ok && type_known) |=> msg_type_r == $past(cmd_type[2:0]);
    endproperty
    a_take_type: assert property (p_take_type) else $error("type not taken");

    property p_head_type;
        @(posedge clk_sys_i) disable iff (srst_i)
        frame_start |=> tx_r[42:40] == $past(msg_type_r);
    endproperty
    a_head_type: assert property (p_head_type) else $error("status type bits wrong");

    property p_csum_load;
        @(posedge clk_sys_i) disable iff (srst_i)
        (frame_start && $stable(head)) |=> 8'(tx_r[47:40] + tx_r[39:32] + tx_r[31:24]
                          + tx_r[23:16] + tx_r[15:8] + tx_r[7:0]) == 8'hFF;
    endproperty
    a_csum_load: assert property (p_csum_load) else $error("output checksum wrong");

    property p_reset_type;
        @(posedge clk_sys_i) srst_i |=> msg_type_r == accel_frame_pkg::MSG_RESET;
    endproperty
    a_reset_type: assert property (p_reset_type) else $error("reset type not accel");

    property p_stat_byte2;
        @(posedge clk_sys_i) disable iff (srst_i)
        is_status |-> data_sel[23:16] == 8'h00 && data_sel[15:0] == temp_r;
    endproperty
    a_stat_byte2: assert property (p_stat_byte2) else $error("status byte two wrong");

    property p_offset;
        @(posedge clk_sys_i) disable iff (srst_i)
        (selftest_r && !is_status) |-> data_sel[31:16] == 16'(accel_y_r + offset_r);
    endproperty
    a_offset: assert property (p_offset) else $error("self-test offset missing");

    property p_shift;
        @(posedge clk_sys_i) disable iff (srst_i)
        (fall && !frame_start) |=> tx_r[47:1] == $past(tx_r[46:0]);
    endproperty
    a_shift: assert property (p_shift) else $error("shift order wrong");

endmodule
`default_nettype wire

// ---- inc/accel_frame_pkg.sv ----
`default_nettype none
package accel_frame_pkg;
    // Frame geometry
    localparam int FRAME_BYTES = 6;
    localparam int FRAME_BITS  = 48;
    // Message types in the low nibble of the command byte
    localparam logic [3:0] MSG_ACCEL  = 4'h1;
    localparam logic [3:0] MSG_STATUS = 4'h2;
    localparam logic [2:0] MSG_RESET  = 3'h1;
    // Command byte fields
    localparam int CMD_SELFTEST_BIT = 6;
    // Status byte positions
    localparam int STAT_SENSOR_BIT  = 7;
    localparam int STAT_ACCY_BIT    = 6;
    localparam int STAT_ACCX_BIT    = 5;
    localparam int STAT_CSUM_BIT    = 4;
    localparam int STAT_SELFTEST    = 3;
    // Self-test settling time
    localparam int SELFTEST_MS      = 35;
    localparam int CLK_HZ           = 125_000_000;
    localparam int SELFTEST_CYC     = (SELFTEST_MS * (CLK_HZ / 1000)) - 1;
    // AXI4-Lite register offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ACCEL  = 8'h04;
    localparam logic [7:0] REG_TEMP   = 8'h08;
    localparam logic [7:0] REG_FAULT  = 8'h0C;
    localparam logic [7:0] REG_OFFSET = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [15:0] OFFSET_RST = 16'h0400;
    // Fault flags fed by software
    typedef struct packed {
        logic       otp_parity;
        logic       acc_cap;
        logic       vref_cap;
        logic [1:0] axis;      // Bit 1 X, bit 0 Y
        logic       sensor;
    } fault_t;
endpackage
`default_nettype wire

// ---- bench/spi_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Host side of the serial link: mode 0 master
module spi_host_model (
    output logic      sclk_o,
    output logic      sel_n_o,
    output logic      mosi_o,
    input  wire logic miso_i
);
    localparam realtime HALF = 62.5;

    // Idle levels follow the pull-ups; the clock parks low outside frames
    initial begin
        sclk_o = 1'b0;
        sel_n_o = 1'b1;
        mosi_o = 1'b1;
    end

    // One whole frame; bad flips the checksum LSB so the device must refuse it
    task automatic xfer(input logic [7:0] cmd, input logic bad, output logic [47:0] rx);
        logic [7:0]  sum;
        logic [47:0] tx;
        // inverted low byte of the byte sum
        sum = ~cmd;
        // type and self-test in command byte, data bytes zero
        tx = {cmd, 32'h0, sum ^ {7'h0, bad}};
        sel_n_o = 1'b0;
        #(HALF);
        // forty-eight bits MSB first, sampled on the rising clock
        for (int i = 47; i >= 0; i--) begin
            mosi_o = tx[i];
            #(HALF);
            sclk_o = 1'b1;
            // whole response kept, status included, whatever its checksum
            rx[i] = miso_i;
            #(HALF);
            sclk_o = 1'b0;
        end
        #(HALF);
        sel_n_o = 1'b1;
        mosi_o = 1'b1;
        // Gap gives the device time to prepare the next checksum
        #(500);
    endtask
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
    // ============================================================
    // Signals and state
    localparam int SETTLE = 200;
    localparam int CEIL   = 20000;
    logic                     clk_sys_i;
    logic                     srst_i;
    wire logic                sclk_w;
    wire logic                sel_n_w;
    wire logic                mosi_w;
    wire logic                miso_w;
    logic                     miso_o;
    logic                     miso_oe_o;
    logic                     miso_hold;
    logic [7:0]               s_axi_awaddr;
    logic                     s_axi_awvalid;
    logic                     s_axi_awready;
    logic [31:0]              s_axi_wdata;
    logic                     s_axi_wvalid;
    logic                     s_axi_wready;
    logic [1:0]               s_axi_bresp;
    logic                     s_axi_bvalid;
    logic                     s_axi_bready;
    logic [7:0]               s_axi_araddr;
    logic                     s_axi_arvalid;
    logic                     s_axi_arready;
    logic [31:0]              s_axi_rdata;
    logic [1:0]               s_axi_rresp;
    logic                     s_axi_rvalid;
    logic                     s_axi_rready;
    int                       n_fail;
    int                       cmp_count;
    int                       cyc;
    accel_frame_pkg::fault_t  flt;
    logic [15:0]              acc_y;
    logic [15:0]              acc_x;
    logic [15:0]              temp;
    logic [15:0]              off;
    logic [31:0]              rd;
    logic [1:0]               resp;
    logic [47:0]              rx;

    accel_frame_core #(
        .SETTLE_CYC (SETTLE)
    ) uut (
        .clk_sys_i     (clk_sys_i),
        .srst_i        (srst_i),
        .sclk_i        (sclk_w),
        .sel_n_i       (sel_n_w),
        .mosi_i        (mosi_w),
        .miso_o        (miso_o),
        .miso_oe_o     (miso_oe_o),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (4'hF),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready)
    );
    spi_host_model host (
        .sclk_o  (sclk_w),
        .sel_n_o (sel_n_w),
        .mosi_o  (mosi_w),
        .miso_i  (miso_w)
    );

    // Released data line shows the inverse of its last value, never a lucky match
    always @(posedge clk_sys_i) if (miso_oe_o) miso_hold <= miso_o;
    assign miso_w = miso_oe_o ? miso_o : ~miso_hold;

    // ============================================================
    // Checking and bus tasks
    task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_p;
        logic w_p;
        logic aw_h;
        logic w_h;
        aw_p = 1'b1;
        w_p = 1'b1;
        @(posedge clk_sys_i);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw_p || w_p) begin
            @(negedge clk_sys_i);
            aw_h = aw_p && (s_axi_awready === 1'b1);
            w_h = w_p && (s_axi_wready === 1'b1);
            @(posedge clk_sys_i);
            if (aw_h) s_axi_awvalid <= 1'b0;
            if (w_h) s_axi_wvalid <= 1'b0;
            aw_p = aw_p && !aw_h;
            w_p = w_p && !w_h;
        end
        @(negedge clk_sys_i);
        while (s_axi_bvalid !== 1'b1) @(negedge clk_sys_i);
        resp = s_axi_bresp;
        @(posedge clk_sys_i);
        s_axi_bready <= 1'b0;
        chk("bresp", resp, er);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk_sys_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(negedge clk_sys_i);
        while (s_axi_arready !== 1'b1) @(negedge clk_sys_i);
        @(posedge clk_sys_i);
        s_axi_arvalid <= 1'b0;
        @(negedge clk_sys_i);
        while (s_axi_rvalid !== 1'b1) @(negedge clk_sys_i);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        @(posedge clk_sys_i);
        s_axi_rready <= 1'b0;
        chk(what, rd & m, ed);
        chk("rresp", resp, er);
    endtask

    // Expected first five bytes for a given type, checksum flag and self-test state
    function automatic logic [39:0] ex(input logic [2:0] ty, input logic cs, input logic st);
        logic [7:0]  sb;
        logic [15:0] add;
        sb = {flt.sensor, flt.axis[0], flt.axis[1], cs, st, ty};
        add = st ? off : 16'h0000;
        if (ty == 3'h1) begin
            return {sb, acc_y + add, acc_x + add};
        end
        return {sb, flt.axis[1], flt.axis[0], flt.vref_cap, flt.acc_cap, st,
                flt.otp_parity, cs, 1'b1, 8'h00, temp};
    endfunction

    task automatic frame(input logic [7:0] cmd, input logic bad, input logic [39:0] e);
        logic [7:0] s;
        // Start off the clock edge so select never races its sampling flop
        @(negedge clk_sys_i);
        host.xfer(cmd, bad, rx);
        s = ~(e[39:32] + e[31:24] + e[23:16] + e[15:8] + e[7:0]);
        chk("response frame", rx, {e, s});
        chk("miso released", miso_oe_o, 1'b0);
    endtask

    // ============================================================
    // Scenarios
    task automatic t_regs;
        rd_chk("offset reset", accel_frame_pkg::REG_OFFSET, 32'hFFFF,
               {16'h0, accel_frame_pkg::OFFSET_RST}, accel_frame_pkg::RESP_OKAY);
        rd_chk("power-up type", accel_frame_pkg::REG_STATUS, 32'h1F, 32'h01,
               accel_frame_pkg::RESP_OKAY);
        rd_chk("unmapped read", 8'h18, 32'hFFFFFFFF, 32'h0, accel_frame_pkg::RESP_SLVERR);
        axi_wr(8'h1C, 32'h0, accel_frame_pkg::RESP_SLVERR);
        axi_wr(accel_frame_pkg::REG_ACCEL, {acc_y, acc_x}, accel_frame_pkg::RESP_OKAY);
        axi_wr(accel_frame_pkg::REG_TEMP, {16'h0, temp}, accel_frame_pkg::RESP_OKAY);
        axi_wr(accel_frame_pkg::REG_OFFSET, {16'h0, off}, accel_frame_pkg::RESP_OKAY);
    endtask

    task automatic t_status;
        frame(8'h02, 1'b0, ex(3'h1, 1'b0, 1'b0));
        flt = 6'h2A;
        axi_wr(accel_frame_pkg::REG_FAULT, {26'h0, flt}, accel_frame_pkg::RESP_OKAY);
        frame(8'h02, 1'b0, ex(3'h2, 1'b0, 1'b0));
        flt = 6'h15;
        axi_wr(accel_frame_pkg::REG_FAULT, {26'h0, flt}, accel_frame_pkg::RESP_OKAY);
        frame(8'h01, 1'b0, ex(3'h2, 1'b0, 1'b0));
    endtask

    task automatic t_bad_sum;
        frame(8'h02, 1'b1, ex(3'h1, 1'b0, 1'b0));
        rd_chk("refused frame", accel_frame_pkg::REG_STATUS, 32'h0F, 32'h09,
               accel_frame_pkg::RESP_OKAY);
        frame(8'h02, 1'b0, ex(3'h1, 1'b1, 1'b0));
        frame(8'h01, 1'b0, ex(3'h2, 1'b0, 1'b0));
    endtask

    task automatic t_selftest;
        frame(8'h41, 1'b0, ex(3'h1, 1'b0, 1'b0));
        rd_chk("self-test pending", accel_frame_pkg::REG_STATUS, 32'h30, 32'h10,
               accel_frame_pkg::RESP_OKAY);
        repeat (SETTLE + 8) @(posedge clk_sys_i);
        rd_chk("self-test settled", accel_frame_pkg::REG_STATUS, 32'h30, 32'h30,
               accel_frame_pkg::RESP_OKAY);
        frame(8'h01, 1'b0, ex(3'h1, 1'b0, 1'b1));
        // host lets the sensor settle before trusting readings
        repeat (SETTLE) @(posedge clk_sys_i);
        frame(8'h01, 1'b0, ex(3'h1, 1'b0, 1'b0));
        axi_wr(accel_frame_pkg::REG_CTRL, 32'h1, accel_frame_pkg::RESP_OKAY);
        frame(8'h01, 1'b0, ex(3'h1, 1'b0, 1'b1));
    endtask

    // ============================================================
    // Clock, reset, sequence and hang guard
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == CEIL) begin
            n_fail++;
            close_out();
        end
    end

    initial begin
        srst_i = 1'b1;
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        n_fail = 0;
        cmp_count = 0;
        cyc = 0;
        flt = 6'h00;
        acc_y = 16'h8123;
        acc_x = 16'h7F45;
        temp = 16'hFF38;
        off = 16'h0C35;
        repeat (16) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        t_regs();
        t_status();
        t_bad_sum();
        t_selftest();
        close_out();
    end
endmodule
`default_nettype wire
